// ### design/cpu_core_state_registers.sv
/*
  architectural state of the core: status word, stack pointer, data pointer
  and program counter, updated by the instruction datapath.
  assumes the datapath sends one-cycle strobes, synchronous to clk_i, and
  reads special registers combinationally through its own mux on our outputs.
*/
// Behaviour
// - two status bits select register bank base 0x00, 0x08, 0x10 or 0x18
// - user flags bits 5 and 1 store software writes only
// - stack pointer is eight bits, reset value 0x07
// - stack pointer increments before push or call stores data
// - data pointer is sixteen bits from low and high byte registers
// - data pointer loads as sixteen-bit word or per byte
// - data pointer addresses code reads indexed by accumulator and external data
// - program counter is sixteen bits, reset to 0x0000
// - program counter advances on opcode fetch and code operand read
// - program counter has no special register address
// - state registers support the generic classic instruction set semantics
`timescale 1ns/100ps
module cpu_core_state_registers (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic [7:0]  accumulator_i,
  input  wire logic        sfr_write_i,
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        carry_write_i,
  input  wire logic        carry_i,
  input  wire logic        nibble_carry_write_i,
  input  wire logic        nibble_carry_i,
  input  wire logic        overflow_write_i,
  input  wire logic        overflow_i,
  input  wire logic        stack_push_i,
  input  wire logic        stack_pop_i,
  input  wire logic        data_pointer_load_i,
  input  wire logic [15:0] data_pointer_wdata_i,
  input  wire logic        data_pointer_increment_i,
  input  wire logic        program_counter_step_i,
  input  wire logic        program_counter_load_i,
  input  wire logic [15:0] program_counter_target_i,
  output logic      [7:0]  program_status_word_o,
  output logic      [7:0]  stack_pointer_o,
  output logic      [7:0]  stack_write_addr_o,
  output logic      [15:0] data_pointer_o,
  output logic      [15:0] code_read_addr_o,
  output logic      [7:0]  bank_base_o,
  output logic      [15:0] program_counter_o
);

  // ==========================================================
  // decoders
  function automatic logic sfr_hit(
    input logic       we,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    sfr_hit = we && (addr == target);
  endfunction : sfr_hit

  // bank base is a pure decode of the two select bits
  function automatic logic [7:0] bank_base_of(
    input logic [7:0] status
  );
    logic [1:0] sel;
    sel          = {status[core_state_pkg::STATUS_BANK_HI_BIT], status[core_state_pkg::STATUS_BANK_LO_BIT]};
    bank_base_of = core_state_pkg::BANK_STRIDE * {6'h00, sel};
  endfunction : bank_base_of

  logic status_hit;
  logic stack_hit;
  logic low_hit;
  logic high_hit;

  assign status_hit = sfr_hit(sfr_write_i, sfr_addr_i, core_state_pkg::STATUS_WORD_ADDR);
  assign stack_hit  = sfr_hit(sfr_write_i, sfr_addr_i, core_state_pkg::STACK_POINTER_ADDR);
  assign low_hit    = sfr_hit(sfr_write_i, sfr_addr_i, core_state_pkg::DATA_POINTER_LOW_ADDR);
  assign high_hit   = sfr_hit(sfr_write_i, sfr_addr_i, core_state_pkg::DATA_POINTER_HIGH_ADDR);

  // ==========================================================
  // status word and bank base
  logic [7:0]  program_status_word;
  logic [7:0]  next_program_status_word;
  logic [7:0]  bank_base;
  logic [7:0]  next_bank_base;

  always_comb begin
    next_program_status_word = program_status_word;
    // software write lands first so the alu flags of the same cycle win
    if (status_hit) begin
      next_program_status_word = sfr_wdata_i;
    end
    if (carry_write_i) begin
      next_program_status_word[core_state_pkg::STATUS_CARRY_BIT] = carry_i;
    end
    if (nibble_carry_write_i) begin
      next_program_status_word[core_state_pkg::STATUS_NIBBLE_BIT] = nibble_carry_i;
    end
    if (overflow_write_i) begin
      next_program_status_word[core_state_pkg::STATUS_OVERFLOW_BIT] = overflow_i;
    end
    // parity follows the accumulator every enabled cycle, writes to it are dropped
    next_program_status_word[core_state_pkg::STATUS_PARITY_BIT] = ^accumulator_i;
    // taken from the next value so the base never lags the select bits
    next_bank_base = bank_base_of(next_program_status_word);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      program_status_word <= core_state_pkg::STATUS_WORD_RST;
      bank_base           <= core_state_pkg::BANK_BASE_RST;
    end else if (clk_en_i) begin
      program_status_word <= next_program_status_word;
      bank_base           <= next_bank_base;
    end
  end

  // ==========================================================
  // stack pointer
  logic [7:0]  stack_pointer;
  logic [7:0]  next_stack_pointer;
  logic [7:0]  stack_write_addr;
  logic [7:0]  next_stack_write_addr;

  always_comb begin
    next_stack_pointer = stack_pointer;
    if (stack_hit) begin
      next_stack_pointer = sfr_wdata_i;
    end else if (stack_push_i) begin
      next_stack_pointer = stack_pointer + core_state_pkg::STACK_STEP;
    end else if (stack_pop_i) begin
      next_stack_pointer = stack_pointer - core_state_pkg::STACK_STEP;
    end
    // follows the new pointer whatever moved it, so a push never waits a cycle
    next_stack_write_addr = next_stack_pointer + core_state_pkg::STACK_STEP;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stack_pointer    <= core_state_pkg::STACK_POINTER_RST;
      stack_write_addr <= core_state_pkg::STACK_WRITE_ADDR_RST;
    end else if (clk_en_i) begin
      stack_pointer    <= next_stack_pointer;
      stack_write_addr <= next_stack_write_addr;
    end
  end

  // ==========================================================
  // data pointer and code read address
  logic [7:0]  data_pointer_low;
  logic [7:0]  data_pointer_high;
  logic [7:0]  next_data_pointer_low;
  logic [7:0]  next_data_pointer_high;
  logic [15:0] code_read_addr;
  logic [15:0] next_code_read_addr;

  always_comb begin
    logic [15:0] pointer_now;
    pointer_now            = {data_pointer_high, data_pointer_low};
    next_data_pointer_low  = data_pointer_low;
    next_data_pointer_high = data_pointer_high;
    if (data_pointer_load_i) begin
      next_data_pointer_low  = data_pointer_wdata_i[7:0];
      next_data_pointer_high = data_pointer_wdata_i[15:8];
    end else if (data_pointer_increment_i) begin
      {next_data_pointer_high, next_data_pointer_low} = pointer_now + core_state_pkg::WORD_STEP;
    end
    // byte writes outrank the word load, as the store order asks
    if (low_hit) begin
      next_data_pointer_low = sfr_wdata_i;
    end
    if (high_hit) begin
      next_data_pointer_high = sfr_wdata_i;
    end
    // sum wraps at the top of code space, no carry out is kept
    next_code_read_addr = {next_data_pointer_high, next_data_pointer_low} + {8'h00, accumulator_i};
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      data_pointer_low  <= core_state_pkg::DATA_POINTER_BYTE_RST;
      data_pointer_high <= core_state_pkg::DATA_POINTER_BYTE_RST;
      code_read_addr    <= core_state_pkg::CODE_READ_ADDR_RST;
    end else if (clk_en_i) begin
      data_pointer_low  <= next_data_pointer_low;
      data_pointer_high <= next_data_pointer_high;
      code_read_addr    <= next_code_read_addr;
    end
  end

  // ==========================================================
  // program counter
  logic [15:0] program_counter;
  logic [15:0] next_program_counter;

  always_comb begin
    next_program_counter = program_counter;
    // no special register decode here: only control flow moves it
    if (program_counter_load_i) begin
      next_program_counter = program_counter_target_i;
    end else if (program_counter_step_i) begin
      next_program_counter = program_counter + core_state_pkg::WORD_STEP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      program_counter <= core_state_pkg::PROGRAM_COUNTER_RST;
    end else if (clk_en_i) begin
      program_counter <= next_program_counter;
    end
  end

  // ==========================================================
  // outputs

  assign program_status_word_o = program_status_word;
  assign stack_pointer_o       = stack_pointer;
  assign stack_write_addr_o    = stack_write_addr;
  assign data_pointer_o        = {data_pointer_high, data_pointer_low};
  assign code_read_addr_o      = code_read_addr;
  assign bank_base_o           = bank_base;
  assign program_counter_o     = program_counter;

endmodule : cpu_core_state_registers

// ### inc/core_state_pkg.sv
/*
  constants for the core state register block: register addresses, status
  word bit positions, reset values, steps and the register bank stride.
  assumes an eight-bit special register space driven by the core datapath.
*/
package core_state_pkg;
  // ==========================================================
  // special register addresses
  localparam logic [7:0]  STACK_POINTER_ADDR     = 8'h81;
  localparam logic [7:0]  DATA_POINTER_LOW_ADDR  = 8'h82;
  localparam logic [7:0]  DATA_POINTER_HIGH_ADDR = 8'h83;
  localparam logic [7:0]  STATUS_WORD_ADDR       = 8'hD0;
  // ==========================================================
  // values after reset
  localparam logic [7:0]  STACK_POINTER_RST      = 8'h07;
  localparam logic [7:0]  STACK_WRITE_ADDR_RST   = 8'h08;
  localparam logic [7:0]  DATA_POINTER_BYTE_RST  = 8'h00;
  localparam logic [15:0] CODE_READ_ADDR_RST     = 16'h0000;
  localparam logic [7:0]  STATUS_WORD_RST        = 8'h00;
  localparam logic [7:0]  BANK_BASE_RST          = 8'h00;
  localparam logic [15:0] PROGRAM_COUNTER_RST    = 16'h0000;
  // ==========================================================
  // status word bit positions
  localparam int          STATUS_CARRY_BIT       = 7;
  localparam int          STATUS_NIBBLE_BIT      = 6;
  localparam int          STATUS_USER0_BIT       = 5;
  localparam int          STATUS_BANK_HI_BIT     = 4;
  localparam int          STATUS_BANK_LO_BIT     = 3;
  localparam int          STATUS_OVERFLOW_BIT    = 2;
  localparam int          STATUS_USER1_BIT       = 1;
  localparam int          STATUS_PARITY_BIT      = 0;
  // ==========================================================
  // steps and strides
  localparam logic [7:0]  BANK_STRIDE            = 8'h08;
  localparam logic [15:0] WORD_STEP              = 16'h0001;
  localparam logic [7:0]  STACK_STEP             = 8'h01;
endpackage : core_state_pkg

// ### test/core_datapath_model.sv
/*
  datapath stand-in: issues back-to-back opcode fetch strobes.
  assumes start is a one-cycle pulse from the bench.
*/
`timescale 1ns/100ps
module core_datapath_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [7:0] n_fetch_i,
  output logic            pc_step_o
);
  logic [7:0] left = 8'h00;
  always @(posedge clk_i) begin
    left <= start_i ? n_fetch_i : left - {7'h00, left != 8'h00};
  end
  assign pc_step_o = left != 8'h00;
endmodule : core_datapath_model

// ### test/core_state_assertions.sv
/*
  checker for the core state registers, bound to the top module.
  assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module core_state_assertions (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       clk_en_i,
  input wire logic [7:0] accumulator_i,
  input wire logic       sfr_write_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       carry_write_i,
  input wire logic       carry_i,
  input wire logic       stack_push_i,
  input wire logic       program_counter_step_i,
  input wire logic       program_counter_load_i,
  input wire logic [7:0] program_status_word_o,
  input wire logic [7:0] stack_pointer_o,
  input wire logic [7:0] stack_write_addr_o,
  input wire logic [7:0] bank_base_o,
  input wire logic [15:0] program_counter_o
);
  // ====================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // all sfr writes excluded, though only a stack pointer write outranks the push
  sequence push_taken; clk_en_i && stack_push_i && !sfr_write_i; endsequence
  sequence status_untouched; clk_en_i && !(sfr_write_i && sfr_addr_i == 8'hD0); endsequence
  bank_base_a: assert property (bank_base_o == {3'b000, program_status_word_o[4:3], 3'b000})
    else $error("bank base mismatch");
  parity_bit_a: assert property (clk_en_i |=> program_status_word_o[0] == ^$past(accumulator_i))
    else $error("parity bit mismatch");
  user_flags_a: assert property (status_untouched |=> $stable({program_status_word_o[5], program_status_word_o[1]}))
    else $error("user flag changed");
  carry_flag_a: assert property (clk_en_i && carry_write_i |=> program_status_word_o[7] == $past(carry_i))
    else $error("carry flag mismatch");
  push_step_a: assert property (push_taken |=> stack_pointer_o == $past(stack_pointer_o) + 8'h01)
    else $error("push step mismatch");
  push_addr_a: assert property (stack_write_addr_o == stack_pointer_o + 8'h01)
    else $error("push address mismatch");
  pc_fetch_a: assert property (clk_en_i && program_counter_step_i && !program_counter_load_i |=>
    program_counter_o == $past(program_counter_o) + 16'h0001) else $error("pc step mismatch");
  frozen_state_a: assert property (!clk_en_i |=> $stable(stack_pointer_o) && $stable(program_counter_o))
    else $error("state moved while frozen");
endmodule : core_state_assertions

bind cpu_core_state_registers core_state_assertions checker_inst (
  .clk_i                  (clk_i),
  .sys_rst_i              (sys_rst_i),
  .clk_en_i               (clk_en_i),
  .accumulator_i          (accumulator_i),
  .sfr_write_i            (sfr_write_i),
  .sfr_addr_i             (sfr_addr_i),
  .carry_write_i          (carry_write_i),
  .carry_i                (carry_i),
  .stack_push_i           (stack_push_i),
  .program_counter_step_i (program_counter_step_i),
  .program_counter_load_i (program_counter_load_i),
  .program_status_word_o  (program_status_word_o),
  .stack_pointer_o        (stack_pointer_o),
  .stack_write_addr_o     (stack_write_addr_o),
  .bank_base_o            (bank_base_o),
  .program_counter_o      (program_counter_o)
);

// ### test/test_cpu_core_state_registers.sv
/*
  self-checking bench for the core state registers.
  assumes the datapath model supplies the fetch strobes.
*/
`timescale 1ns/100ps
module test_cpu_core_state_registers;
  typedef struct {logic [7:0] a, d; logic [15:0] e;} row_t;
  logic clk_i = 0, sys_rst_i = 1, clk_en_i = 0, sfr_write_i = 0, carry_write_i = 0, carry_i = 0, start = 0;
  logic nibble_carry_write_i = 0, nibble_carry_i = 0, overflow_write_i = 0, overflow_i = 0, program_counter_step_i;
  logic stack_push_i = 0, stack_pop_i = 0, data_pointer_load_i = 0, data_pointer_increment_i = 0;
  logic program_counter_load_i = 0;
  logic [7:0] accumulator_i = 0, sfr_addr_i = 0, sfr_wdata_i = 0, program_status_word_o, stack_pointer_o;
  logic [7:0] stack_write_addr_o, bank_base_o;
  logic [15:0] data_pointer_wdata_i = 0, program_counter_target_i = 0, data_pointer_o, code_read_addr_o;
  logic [15:0] program_counter_o;
  int n_fail = 0, num_checks = 0;
  // last row: unmapped address must leave the pointer alone
  row_t rows [8] = '{'{8'hD0, 8'h18, 16'h0018}, '{8'hD0, 8'h08, 16'h0008}, '{8'hD0, 8'h10, 16'h0010},
    '{8'hD0, 8'h00, 16'h0000}, '{8'h81, 8'h3F, 16'h003F}, '{8'h82, 8'h34, 16'h0034},
    '{8'h83, 8'h12, 16'h1234}, '{8'h55, 8'hFF, 16'h1234}};
  always #5 clk_i = ~clk_i;
  cpu_core_state_registers DUT (.*);
  core_datapath_model partner (.clk_i, .start_i(start), .n_fetch_i(8'h03), .pc_step_o(program_counter_step_i));
  // ====================
  // tasks
  task chk8(input logic [7:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task chk16(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task go;
    @(posedge clk_i);
    {sfr_write_i, carry_write_i, nibble_carry_write_i, overflow_write_i} <= '0;
    {stack_push_i, stack_pop_i, data_pointer_load_i, data_pointer_increment_i, program_counter_load_i, start} <= '0;
    #1;
  endtask : go
  task put(input logic [7:0] a, d);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_write_i <= 1;
  endtask : put
  function automatic logic [15:0] obs(input logic [7:0] a);
    return a == 8'hD0 ? {8'h00, bank_base_o} : a == 8'h81 ? {8'h00, stack_pointer_o} : data_pointer_o;
  endfunction : obs
  task give_verdict;
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  // ====================
  // sequence
  initial begin
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 0;
    clk_en_i <= 1;
    #1;
    chk8(stack_pointer_o, 8'h07);
    chk16(program_counter_o, 16'h0000);
    chk16(data_pointer_o, 16'h0000);
    @(posedge clk_i) stack_push_i <= 1;
    go;
    chk8(stack_write_addr_o, 8'h09);
    chk8(stack_pointer_o, 8'h08);
    foreach (rows[i]) begin
      @(posedge clk_i) put(rows[i].a, rows[i].d);
      go;
      chk16(obs(rows[i].a), rows[i].e);
    end
    @(posedge clk_i) put(8'hD0, 8'h22);
    {carry_write_i, carry_i, nibble_carry_write_i, nibble_carry_i, overflow_write_i, overflow_i} <= '1;
    accumulator_i <= 8'h07;
    go;
    chk8(program_status_word_o, 8'hE7);
    @(posedge clk_i) {carry_write_i, carry_i, accumulator_i} <= 10'h200;
    go;
    chk8(program_status_word_o, 8'h66);
    @(posedge clk_i) put(8'hD0, 8'h23);
    go;
    chk8(program_status_word_o, 8'h22);
    @(posedge clk_i) {data_pointer_load_i, data_pointer_wdata_i, accumulator_i} <= {1'b1, 16'hA5F0, 8'h07};
    go;
    chk16(data_pointer_o, 16'hA5F0);
    go;
    chk16(code_read_addr_o, 16'hA5F7);
    @(posedge clk_i) {data_pointer_increment_i, stack_pop_i} <= 2'b11;
    go;
    chk16(data_pointer_o, 16'hA5F1);
    chk16(code_read_addr_o, 16'hA5F8);
    chk8(stack_pointer_o, 8'h3E);
    chk8(stack_write_addr_o, 8'h3F);
    @(posedge clk_i) start <= 1;
    go;
    repeat (3) @(posedge clk_i);
    #1;
    chk16(program_counter_o, 16'h0003);
    @(posedge clk_i) {program_counter_load_i, program_counter_target_i} <= {1'b1, 16'h0100};
    go;
    chk16(program_counter_o, 16'h0100);
    @(posedge clk_i) {clk_en_i, stack_push_i} <= 2'b01;
    go;
    chk8(stack_pointer_o, 8'h3E);
    // second reset in mid-run, with the enable still low
    @(posedge clk_i) sys_rst_i <= 1;
    @(posedge clk_i) sys_rst_i <= 0;
    #1;
    chk8(stack_pointer_o, 8'h07);
    chk8(stack_write_addr_o, 8'h08);
    chk16(program_counter_o, 16'h0000);
    chk8(bank_base_o, 8'h00);
    give_verdict;
  end
endmodule : test_cpu_core_state_registers
